/* logic/ubt_pkg.sv */
// Shared constants for the universal bus transceiver block.
// Assumes a single 40 MHz clock domain and a synchronous active-low reset.
package ubt_pkg;
  localparam int DATA_W = 18;
  localparam int SNOOP_DEPTH = 8;
  localparam int DIR_COUNT = 2;
  localparam int DIR_A_TO_B = 0;
  localparam int DIR_B_TO_A = 1;
  localparam logic [DATA_W-1:0] STORE_RESET = 18'h00000;
  localparam logic OE_RESET = 1'b0;
  localparam logic PEND_RESET = 1'b0;
  localparam logic EDGE_PREV_RESET = 1'b0;
  localparam logic CLOCK_PREV_RESET = 1'b1;
endpackage

/* logic/ubt_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes the filling side honours inReady and the draining side may stall freely.
`timescale 1ns/1ps
module ubt_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Filling side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = PW'(0) + (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PW:0] count_q, count_d;
  logic notFull_q, notFull_d, notEmpty_q, notEmpty_d;
  logic push, pop;
  logic [WIDTH-1:0] head_q, head_d;

  assign push = inValid && notFull_q;
  assign pop = outReady && notEmpty_q;
  assign inReady = notFull_q;
  assign outValid = notEmpty_q;
  assign outData = head_q;

  // Pointers wrap at DEPTH, so DEPTH need not be a power of two.
  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      wrPtr_d = (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    end
    if (pop) begin
      rdPtr_d = (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
    notFull_d = (count_d != DEPTH_CNT);
    notEmpty_d = (count_d != '0);
    // The head word is registered; a word pushed into the head slot bypasses memory.
    if (push && (rdPtr_d == wrPtr_q)) begin
      head_d = inData;
    end else begin
      head_d = mem[rdPtr_d];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      notFull_q <= 1'b1;
      notEmpty_q <= 1'b0;
      head_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      notFull_q <= notFull_d;
      notEmpty_q <= notEmpty_d;
      head_q <= head_d;
    end
  end

  // Storage needs no reset; only written words are ever read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule

/* logic/ubt_transceiver.sv */
// Eighteen-bit bidirectional bus transceiver with per-direction latch, clock and enable.
// Assumes every control and data input is synchronous to clk; edges are seen by sampling.
//
// Function
// - A-to-B latch enable high passes side-one data transparently into storage.
// - Latch enable low and steady clock keep A-to-B storage unchanged.
// - Latch enable low: clock falling edge captures side-one data.
// - A-to-B output enable high drives side-two pins from A-to-B storage.
// - Enable low floats side-two pins; storage keeps latching, clocking or holding.
// - B-to-A path mirrors A-to-B, with an active-low output enable.
// - Latch enable falling edge freezes the value present just before it, unless the clock falls in the same cycle and captures new data.
// - Eighteen bits per direction, bit n maps to bit n.
// - All paths are non-inverting.
`timescale 1ns/1ps
module ubt_transceiver #(
  parameter int WIDTH = ubt_pkg::DATA_W,
  parameter int SNOOP_DEPTH = ubt_pkg::SNOOP_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Direction controls.
  input wire logic aToBOutEnable,
  input wire logic bToAOutEnableN,
  input wire logic aToBLatchEn,
  input wire logic bToALatchEn,
  input wire logic aToBClockN,
  input wire logic bToAClockN,
  // Side one data pins.
  input wire logic [WIDTH-1:0] sideOneDataIn,
  output logic [WIDTH-1:0] sideOneDataOut,
  output logic sideOneDataOe,
  // Side two data pins.
  input wire logic [WIDTH-1:0] sideTwoDataIn,
  output logic [WIDTH-1:0] sideTwoDataOut,
  output logic sideTwoDataOe,
  // Stream of stored words, at most one per latch freeze or clock capture.
  output logic snoopValid,
  input wire logic snoopReady,
  output logic [WIDTH:0] snoopData,
  output logic snoopSpace
);
  localparam int ND = ubt_pkg::DIR_COUNT;
  localparam int AB = ubt_pkg::DIR_A_TO_B;
  localparam int BA = ubt_pkg::DIR_B_TO_A;

  logic [WIDTH-1:0] dirIn [ND];
  logic [WIDTH-1:0] store_q [ND];
  logic [ND-1:0] latchEn, clockN, outEn, oe_q, pend_q, grant;
  logic fifoInReady;
  logic fifoInValid;
  logic [WIDTH:0] fifoInData;

  // Gather both directions into common form; the B-to-A enable is active low.
  assign dirIn[AB] = sideOneDataIn;
  assign dirIn[BA] = sideTwoDataIn;
  assign latchEn = {bToALatchEn, aToBLatchEn};
  assign clockN = {bToAClockN, aToBClockN};
  assign outEn = {!bToAOutEnableN, aToBOutEnable};

  genvar d;
  generate
    for (d = 0; d < ND; d++) begin : g_dir
      logic [WIDTH-1:0] store_d;
      logic latchPrev_q, clockPrev_q, oe_d, pend_d, event_d;
      logic latchPrev_d, clockPrev_d;

      always_comb begin
        store_d = store_q[d];
        event_d = 1'b0;
        if (latchEn[d]) begin
          store_d = dirIn[d];
        end else if (clockPrev_q && !clockN[d]) begin
          store_d = dirIn[d];
          event_d = 1'b1;
        end else if (latchPrev_q) begin
          event_d = 1'b1;
        end
        oe_d = outEn[d];
        // A new event wins over the grant that clears the pending flag.
        pend_d = event_d || (pend_q[d] && !grant[d]);
        latchPrev_d = latchEn[d];
        clockPrev_d = clockN[d];
      end

      always_ff @(posedge clk) begin
        if (!rst_b) begin
          store_q[d] <= ubt_pkg::STORE_RESET;
          oe_q[d] <= ubt_pkg::OE_RESET;
          pend_q[d] <= ubt_pkg::PEND_RESET;
          latchPrev_q <= ubt_pkg::EDGE_PREV_RESET;
          clockPrev_q <= ubt_pkg::CLOCK_PREV_RESET;
        end else begin
          store_q[d] <= store_d;
          oe_q[d] <= oe_d;
          pend_q[d] <= pend_d;
          latchPrev_q <= latchPrev_d;
          clockPrev_q <= clockPrev_d;
        end
      end
    end
  endgenerate

  // Drive each side from the opposite direction's storage, bit for bit.
  assign sideTwoDataOut = store_q[AB];
  assign sideTwoDataOe = oe_q[AB];
  assign sideOneDataOut = store_q[BA];
  assign sideOneDataOe = oe_q[BA];

  // A-to-B events take the FIFO first; a waiting event stays pending.
  always_comb begin
    grant = '0;
    if (fifoInReady) begin
      if (pend_q[AB]) begin
        grant[AB] = 1'b1;
      end else if (pend_q[BA]) begin
        grant[BA] = 1'b1;
      end
    end
    fifoInValid = |pend_q;
    fifoInData = pend_q[AB] ? {1'(AB), store_q[AB]} : {1'(BA), store_q[BA]};
  end

  assign snoopSpace = fifoInReady;

  ubt_fifo #(
    .WIDTH(WIDTH + 1),
    .DEPTH(SNOOP_DEPTH)
  ) u_snoop (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(snoopValid),
    .outReady(snoopReady),
    .outData(snoopData)
  );
endmodule

/* sim/ubt_transceiver_assertions.sv */
// Checker on the transceiver ports.
// Assumes a bind into ubt_transceiver.
`timescale 1ns/1ps
module ubt_transceiver_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports.
  input wire logic aToBOutEnable,
  input wire logic bToAOutEnableN,
  input wire logic aToBLatchEn,
  input wire logic bToALatchEn,
  input wire logic aToBClockN,
  input wire logic bToAClockN,
  input wire logic [17:0] sideOneDataIn,
  input wire logic [17:0] sideOneDataOut,
  input wire logic sideOneDataOe,
  input wire logic [17:0] sideTwoDataIn,
  input wire logic [17:0] sideTwoDataOut,
  input wire logic sideTwoDataOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ab_pass_a: assert property (aToBLatchEn |=> sideTwoDataOut == $past(sideOneDataIn))
    else $error("ab pass");
  ab_hold_a: assert property ($past(rst_b) && !aToBLatchEn && !$fell(aToBClockN)
    |=> $stable(sideTwoDataOut)) else $error("ab hold");
  ab_cap_a: assert property (!aToBLatchEn && $fell(aToBClockN)
    |=> sideTwoDataOut == $past(sideOneDataIn)) else $error("ab capture");
  ab_oe_a: assert property (rst_b |=> sideTwoDataOe == $past(aToBOutEnable))
    else $error("ab enable");
  ba_pass_a: assert property (bToALatchEn |=> sideOneDataOut == $past(sideTwoDataIn))
    else $error("ba pass");
  ba_hold_a: assert property ($past(rst_b) && !bToALatchEn && !$fell(bToAClockN)
    |=> $stable(sideOneDataOut)) else $error("ba hold");
  ba_cap_a: assert property (!bToALatchEn && $fell(bToAClockN)
    |=> sideOneDataOut == $past(sideTwoDataIn)) else $error("ba capture");
  ba_oe_a: assert property (rst_b |=> sideOneDataOe != $past(bToAOutEnableN))
    else $error("ba enable");
  reset_float_a: assert property (disable iff (1'b0) !rst_b
    |=> !sideOneDataOe && !sideTwoDataOe) else $error("reset enable");
  cover property (!aToBLatchEn && $fell(aToBClockN));
  cover property ($fell(bToALatchEn));
  cover property (sideOneDataOe);
endmodule
bind ubt_transceiver ubt_transceiver_assertions i_ubt_transceiver_assertions (
  .clk(clk),
  .rst_b(rst_b),
  .aToBOutEnable(aToBOutEnable),
  .bToAOutEnableN(bToAOutEnableN),
  .aToBLatchEn(aToBLatchEn),
  .bToALatchEn(bToALatchEn),
  .aToBClockN(aToBClockN),
  .bToAClockN(bToAClockN),
  .sideOneDataIn(sideOneDataIn),
  .sideOneDataOut(sideOneDataOut),
  .sideOneDataOe(sideOneDataOe),
  .sideTwoDataIn(sideTwoDataIn),
  .sideTwoDataOut(sideTwoDataOut),
  .sideTwoDataOe(sideTwoDataOe)
);

/* sim/ubt_bus_model.sv */
// Outside bus on one data side.
// Assumes the device enable wins; a released wire toggles each cycle.
`timescale 1ns/1ps
module ubt_bus_model (
  // Device side.
  input wire logic clk,
  input wire logic devOe,
  input wire logic [17:0] devOut,
  // Outside driver and wire.
  input wire logic extOe,
  input wire logic [17:0] extVal,
  output logic [17:0] level
);
  logic [17:0] last_q = 18'h00000;
  always @(posedge clk) last_q <= level;
  assign level = devOe ? devOut : (extOe ? extVal : ~last_q);
endmodule

/* sim/ubt_transceiver_bench.sv */
// Bench: mode table, then reset and snoop FIFO cases.
// Assumes bus models on both data sides.
`timescale 1ns/1ps
module ubt_transceiver_bench;
  logic clk, rst_b, aToBOutEnable, bToAOutEnableN, aToBLatchEn, bToALatchEn, aToBClockN;
  logic bToAClockN, sideOneDataOe, sideTwoDataOe, snoopValid, snoopReady, snoopSpace;
  logic [17:0] aVal, bVal, sideOneDataIn, sideOneDataOut, sideTwoDataIn, sideTwoDataOut;
  logic [18:0] snoopData;
  logic [87:0] r;
  int mismatches = 0, checks = 0, cyc = 0;
  logic [87:0] rowT [5] = '{88'h1f_15555_0aaaa_15555_0aaaa, 88'h33_3ffff_00000_15555_0aaaa,
    88'h31_00123_00000_00123_0aaaa, 88'h13_00000_1beef_00123_0aaaa,
    88'h02_00000_1beef_00123_1beef};
  ubt_transceiver i_ubt_transceiver (
    .clk(clk),
    .rst_b(rst_b),
    .aToBOutEnable(aToBOutEnable),
    .bToAOutEnableN(bToAOutEnableN),
    .aToBLatchEn(aToBLatchEn),
    .bToALatchEn(bToALatchEn),
    .aToBClockN(aToBClockN),
    .bToAClockN(bToAClockN),
    .sideOneDataIn(sideOneDataIn),
    .sideOneDataOut(sideOneDataOut),
    .sideOneDataOe(sideOneDataOe),
    .sideTwoDataIn(sideTwoDataIn),
    .sideTwoDataOut(sideTwoDataOut),
    .sideTwoDataOe(sideTwoDataOe),
    .snoopValid(snoopValid),
    .snoopReady(snoopReady),
    .snoopData(snoopData),
    .snoopSpace(snoopSpace)
  );
  ubt_bus_model i_ubt_bus_model_a (.clk(clk), .devOe(sideOneDataOe), .devOut(sideOneDataOut),
    .extOe(bToAOutEnableN), .extVal(aVal), .level(sideOneDataIn));
  ubt_bus_model i_ubt_bus_model_b (.clk(clk), .devOe(sideTwoDataOe), .devOut(sideTwoDataOut),
    .extOe(!aToBOutEnable), .extVal(bVal), .level(sideTwoDataIn));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 500) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic drive(logic [5:0] c);
    {aToBOutEnable, bToAOutEnableN, aToBLatchEn, bToALatchEn, aToBClockN, bToAClockN} = c;
  endtask
  task automatic chk(string n, logic [18:0] seen, logic [18:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    snoopReady = 1'b1;
    drive(6'h13);
    aVal = 18'h00000;
    bVal = 18'h00000;
    repeat (3) tick();
    rst_b = 1'b1;
    foreach (rowT[k]) begin
      r = rowT[k];
      drive(r[85:80]);
      aVal = r[77:60];
      bVal = r[57:40];
      tick();
      chk("out2", 19'(sideTwoDataOut), 19'(r[37:20]));
      chk("out1", 19'(sideOneDataOut), 19'(r[17:0]));
      chk("oe", 19'({sideOneDataOe, sideTwoDataOe}), 19'({!r[84], r[85]}));
    end
    drive(6'h13);
    rst_b = 1'b0;
    repeat (3) tick();
    chk("rst", 19'({sideOneDataOe, sideTwoDataOe, snoopValid, snoopSpace}), 19'h00001);
    chk("rst1", 19'(sideOneDataOut), 19'(ubt_pkg::STORE_RESET));
    chk("rst2", 19'(sideTwoDataOut), 19'(ubt_pkg::STORE_RESET));
    rst_b = 1'b1;
    snoopReady = 1'b0;
    for (int i = 1; i < 10; i++) begin
      drive(6'h11);
      aVal = 18'(i);
      tick();
      drive(6'h13);
      tick();
    end
    tick();
    chk("space", 19'(snoopSpace), 19'h00000);
    snoopReady = 1'b1;
    for (int i = 1; i < 10; i++) begin
      for (int w = 0; w < 20 && snoopValid !== 1'b1; w++) tick();
      chk("word", snoopData, 19'(i));
      tick();
    end
    snoopReady = 1'b0;
    aVal = 18'h00abc;
    bVal = 18'h00def;
    drive(6'h10);
    tick();
    drive(6'h13);
    tick();
    tick();
    chk("out1", 19'(sideOneDataOut), 19'h00def);
    chk("hvalid", 19'(snoopValid), 19'h00001);
    chk("head", snoopData, 19'h00abc);
    snoopReady = 1'b1;
    tick();
    chk("tail", snoopData, 19'h40def);
    repeat (3) tick();
    chk("empty", 19'({snoopValid, snoopSpace}), 19'h00001);
    complete_run();
  end
endmodule
